// ### inc/pcsir_pkg.sv
// types of the loop status bank
// assumes the constants of pcsir_regs.svh
package pcsir_pkg;

  // ********************************
  // whole state of the bank
  // ********************************
  typedef struct packed {
    logic stop_s1;
    logic stop_s2;
    logic stop_d;
    logic rdy_s1;
    logic rdy_s2;
    logic resume_ie;
    logic halt_ie;
    logic resume_flag;
    logic halt_flag;
    logic [2:0] state_d;
    logic [2:0] limit_d;
    logic [2:0] state_chg;
    logic [2:0] limit_chg;
    logic [2:0] state_ie;
    logic [2:0] limit_ie;
    logic mismatch;
    logic [23:0] ofs_hi;
    logic [39:0] nominal;
    logic [39:0] tw;
    logic [31:0] prdata;
    logic pslverr;
  } pcsir_state_t;

endpackage : pcsir_pkg

// ### inc/pcsir_regs.svh
// register indices, bit positions and reset values of the loop status bank
// assumes APB word addressing: byte address is four times the index
`ifndef PCSIR_REGS_SVH
`define PCSIR_REGS_SVH

// ********************************
// register indices
// ********************************
`define PCSIR_IDX_OUT_CLK 8'h53
`define PCSIR_IDX_STATE_LIVE 8'h56
`define PCSIR_IDX_LIMIT_LIVE 8'h57
`define PCSIR_IDX_STATE_CHG 8'h59
`define PCSIR_IDX_LIMIT_CHG 8'h5A
`define PCSIR_IDX_STATE_IE 8'h5B
`define PCSIR_IDX_LIMIT_IE 8'h5C
`define PCSIR_IDX_OFS_B0 8'h65
`define PCSIR_OFS_BYTES 4
`define PCSIR_IDX_NOM_B0 8'h70
`define PCSIR_NOM_BYTES 5

// ********************************
// field positions
// ********************************
`define PCSIR_BIT_RESUME_IE 4
`define PCSIR_BIT_RESUME_FLAG 3
`define PCSIR_BIT_HALT_IE 2
`define PCSIR_BIT_HALT_FLAG 1
`define PCSIR_BIT_HALTED 0
`define PCSIR_LSB_STATE 3
`define PCSIR_BIT_MISMATCH 4
`define PCSIR_LSB_LIMIT 0

// ********************************
// reset values
// ********************************
`define PCSIR_RST_ALL '0
`define PCSIR_RD_ZERO 32'h00000000

`endif

// ### rtl/pcsir_regs.sv
// status, change flags and interrupt enables of one loop channel
// assumes loop status inputs come from core_clk logic; the two
// output clock path pins are asynchronous and are synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "pcsir_regs.svh"

// Overview of operation
// - resume flag requests interrupt when enabled
// - resume flag sets on restart, W1C
// - halt flag requests interrupt when enabled
// - halt flag sets on stop, W1C
// - live halted bit follows output stop while path ready
// - output flags zero until path configured
// - lock-lost bit live, meaningful while tracking
// - tracking bit live
// - retained-state bit live, meaningful when idle
// - firmware mismatch sticky, forces freerun
// - offset-limit bit live
// - rate-limit bit live
// - slope-limit bit live
// - state bit changes latch flags, W1C
// - limit bit changes latch flags, W1C
// - enabled state flags drive summary
// - enabled limit flags drive summary
// - signed offset word in four bytes
// - offset added to nominal gives tuning
// - nominal word forty bits, own registers
module pcsir_regs
  import pcsir_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic out_clk_stopped,
  input wire logic out_path_ready,
  input wire logic lock_lost_live,
  input wire logic tracking_live,
  input wire logic retained_tuning_offset_word_state,
  input wire logic offset_limit_active,
  input wire logic rate_limit_active,
  input wire logic phase_slope_limit_active,
  input wire logic firmware_mismatch_in,
  input wire logic [31:0] tuning_offset_word,
  output logic out_clk_irq,
  output logic loop_irq_summary,
  output logic firmware_mismatch_halt,
  output logic [39:0] nominal_tuning_word,
  output logic [39:0] tuning_word
);

  // ********************************
  // elaboration checks
  // ********************************
  // decode needs paddr[9:2]; wider buses alias above bit 9
  generate
    if (ADDR_W < 10)
    begin : g_bad_addr
      $error("pcsir_regs: ADDR_W must be at least 10");
    end
  endgenerate

  // ********************************
  // decode and helpers
  // ********************************
  pcsir_state_t s;
  pcsir_state_t n;
  logic [7:0] idx;
  logic wr_lo;
  logic rd_setup;
  logic [2:0] live_state;
  logic [2:0] live_limit;
  logic [2:0] state_evt;
  logic [2:0] limit_evt;
  logic [2:0] state_clr;
  logic [2:0] limit_clr;
  logic resume_set;
  logic halt_set;
  logic halted_now;
  logic [39:0] ofs_ext;

  // word index and phase qualifiers
  assign idx = paddr[9:2];
  assign wr_lo = psel & penable & pwrite & pstrb[0];
  assign rd_setup = psel & ~penable & ~pwrite;

  // live loop status, no sync: same clock as this bank
  assign live_state = {lock_lost_live, tracking_live, retained_tuning_offset_word_state};
  assign live_limit = {offset_limit_active, rate_limit_active,
                       phase_slope_limit_active};

  // change detection against last cycle's value
  assign state_evt = live_state ^ s.state_d;
  assign limit_evt = live_limit ^ s.limit_d;

  // write-one-clear strobes
  assign state_clr = (wr_lo && idx == `PCSIR_IDX_STATE_CHG) ?
                     pwdata[`PCSIR_LSB_STATE +: 3] : 3'h0;
  assign limit_clr = (wr_lo && idx == `PCSIR_IDX_LIMIT_CHG) ?
                     pwdata[`PCSIR_LSB_LIMIT +: 3] : 3'h0;

  // output clock stop and restart edges, only once path is live
  assign resume_set = s.rdy_s2 & s.stop_d & ~s.stop_s2;
  assign halt_set = s.rdy_s2 & ~s.stop_d & s.stop_s2;
  assign halted_now = s.rdy_s2 & s.stop_s2;

  // offset sign-extended to the width of the nominal word
  assign ofs_ext = {{8{tuning_offset_word[31]}}, tuning_offset_word};

  // ********************************
  // next state
  // ********************************
  always_comb
  begin
    logic oc_wr;
    logic oc_res_clr;
    logic oc_halt_clr;
    logic hit;
    oc_wr = wr_lo && idx == `PCSIR_IDX_OUT_CLK;
    oc_res_clr = oc_wr & pwdata[`PCSIR_BIT_RESUME_FLAG];
    oc_halt_clr = oc_wr & pwdata[`PCSIR_BIT_HALT_FLAG];
    hit = 1'b0;
    n = s;
    // two-stage synchronisers; stage one feeds stage two only
    n.stop_s1 = out_clk_stopped;
    n.stop_s2 = s.stop_s1;
    n.rdy_s1 = out_path_ready;
    n.rdy_s2 = s.rdy_s1;
    n.stop_d = s.stop_s2;
    // output flags settle to zero until the path runs
    if (!s.rdy_s2)
    begin
      n.resume_flag = 1'b0;
      n.halt_flag = 1'b0;
    end
    else
    begin
      // event wins over a clear in the same cycle
      n.resume_flag = (s.resume_flag & ~oc_res_clr) | resume_set;
      n.halt_flag = (s.halt_flag & ~oc_halt_clr) | halt_set;
    end
    if (oc_wr)
    begin
      n.resume_ie = pwdata[`PCSIR_BIT_RESUME_IE];
      n.halt_ie = pwdata[`PCSIR_BIT_HALT_IE];
    end
    // loop change flags
    n.state_d = live_state;
    n.limit_d = live_limit;
    n.state_chg = (s.state_chg & ~state_clr) | state_evt;
    n.limit_chg = (s.limit_chg & ~limit_clr) | limit_evt;
    if (wr_lo && idx == `PCSIR_IDX_STATE_IE)
    begin
      n.state_ie = pwdata[`PCSIR_LSB_STATE +: 3];
    end
    if (wr_lo && idx == `PCSIR_IDX_LIMIT_IE)
    begin
      n.limit_ie = pwdata[`PCSIR_LSB_LIMIT +: 3];
    end
    // only a channel reset leaves the mismatch state
    n.mismatch = s.mismatch | firmware_mismatch_in;
    // nominal word bytes, writable one at a time
    for (int b = 0; b < `PCSIR_NOM_BYTES; b++)
    begin
      if (wr_lo && idx == 8'(`PCSIR_IDX_NOM_B0 + b))
      begin
        n.nominal[8*b +: 8] = pwdata[7:0];
      end
    end
    n.tw = s.nominal + ofs_ext;
    // read data is formed in the setup phase, shown in the access phase
    if (psel && !penable)
    begin
      n.prdata = `PCSIR_RD_ZERO;
      case (idx)
        `PCSIR_IDX_OUT_CLK:
        begin
          hit = 1'b1;
          n.prdata[`PCSIR_BIT_RESUME_IE] = s.resume_ie;
          n.prdata[`PCSIR_BIT_RESUME_FLAG] = s.resume_flag;
          n.prdata[`PCSIR_BIT_HALT_IE] = s.halt_ie;
          n.prdata[`PCSIR_BIT_HALT_FLAG] = s.halt_flag;
          n.prdata[`PCSIR_BIT_HALTED] = halted_now;
        end
        `PCSIR_IDX_STATE_LIVE:
        begin
          hit = 1'b1;
          n.prdata[`PCSIR_LSB_STATE +: 3] = live_state;
        end
        `PCSIR_IDX_LIMIT_LIVE:
        begin
          hit = 1'b1;
          n.prdata[`PCSIR_BIT_MISMATCH] = s.mismatch;
          n.prdata[`PCSIR_LSB_LIMIT +: 3] = live_limit;
        end
        `PCSIR_IDX_STATE_CHG:
        begin
          hit = 1'b1;
          n.prdata[`PCSIR_LSB_STATE +: 3] = s.state_chg;
        end
        `PCSIR_IDX_LIMIT_CHG:
        begin
          hit = 1'b1;
          n.prdata[`PCSIR_LSB_LIMIT +: 3] = s.limit_chg;
        end
        `PCSIR_IDX_STATE_IE:
        begin
          hit = 1'b1;
          n.prdata[`PCSIR_LSB_STATE +: 3] = s.state_ie;
        end
        `PCSIR_IDX_LIMIT_IE:
        begin
          hit = 1'b1;
          n.prdata[`PCSIR_LSB_LIMIT +: 3] = s.limit_ie;
        end
        default:
        begin
          hit = 1'b0;
        end
      endcase
      // low offset byte live; its read freezes the upper three bytes
      // so a low-to-high byte walk sees one coherent word
      if (idx == `PCSIR_IDX_OFS_B0)
      begin
        hit = 1'b1;
        n.prdata[7:0] = tuning_offset_word[7:0];
        if (!pwrite)
        begin
          n.ofs_hi = tuning_offset_word[31:8];
        end
      end
      for (int b = 1; b < `PCSIR_OFS_BYTES; b++)
      begin
        if (idx == 8'(`PCSIR_IDX_OFS_B0 + b))
        begin
          hit = 1'b1;
          n.prdata[7:0] = s.ofs_hi[8*(b-1) +: 8];
        end
      end
      for (int b = 0; b < `PCSIR_NOM_BYTES; b++)
      begin
        if (idx == 8'(`PCSIR_IDX_NOM_B0 + b))
        begin
          hit = 1'b1;
          n.prdata[7:0] = s.nominal[8*b +: 8];
        end
      end
      if (pwrite)
      begin
        n.prdata = `PCSIR_RD_ZERO;
      end
      n.pslverr = ~hit;
    end
  end

  // ********************************
  // state register
  // ********************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s <= `PCSIR_RST_ALL;
    end
    else
    begin
      s <= n;
    end
  end

  // ********************************
  // outputs
  // ********************************
  // zero wait states: every access phase completes at once
  assign pready = psel & penable;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr & psel & penable;
  // interrupt requests to the channel interrupt logic
  assign out_clk_irq = (s.resume_flag & s.resume_ie)
                     | (s.halt_flag & s.halt_ie);
  assign loop_irq_summary = |(s.state_chg & s.state_ie)
                          | |(s.limit_chg & s.limit_ie);
  assign firmware_mismatch_halt = s.mismatch;
  assign nominal_tuning_word = s.nominal;
  assign tuning_word = s.tw;

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  chk_resume_irq_on: assert property (
    s.resume_flag && s.resume_ie |-> out_clk_irq)
    else $error("resume flag enabled but no request");

  chk_out_irq_off: assert property (
    !s.resume_ie && !s.halt_ie |-> !out_clk_irq)
    else $error("output request with both enables clear");

  chk_halt_irq_on: assert property (
    s.halt_flag && s.halt_ie |-> out_clk_irq)
    else $error("halt flag enabled but no request");

  chk_resume_set: assert property (
    resume_set |=> s.resume_flag)
    else $error("restart not latched");

  chk_halt_set: assert property (
    halt_set |=> s.halt_flag)
    else $error("stop not latched");

  chk_halted_read: assert property (
    rd_setup && idx == `PCSIR_IDX_OUT_CLK |=>
      prdata[`PCSIR_BIT_HALTED] == $past(halted_now))
    else $error("halted bit read wrong");

  chk_unready_clear: assert property (
    !s.rdy_s2 |=> !s.resume_flag && !s.halt_flag)
    else $error("output flags kept while path idle");

  chk_mismatch_stay: assert property (
    firmware_mismatch_in |=> firmware_mismatch_halt [*4])
    else $error("mismatch not held");

  // reset is sampled, so the edge that leaves reset starts no check;
  // the bank is cleared there while live inputs may already be high
  chk_state_change: assert property (
    !reset && state_evt != 3'h0 |=>
      (s.state_chg & $past(state_evt)) == $past(state_evt))
    else $error("state change not latched");

  chk_limit_change: assert property (
    !reset && limit_evt != 3'h0 |=>
      (s.limit_chg & $past(limit_evt)) == $past(limit_evt))
    else $error("limit change not latched");

  chk_limit_setwins: assert property (
    (limit_evt & limit_clr) != 3'h0 |=>
      (s.limit_chg & $past(limit_evt)) == $past(limit_evt))
    else $error("clear beat a limit change");

  chk_summary_enable: assert property (
    wr_lo && idx == `PCSIR_IDX_STATE_IE &&
      (pwdata[`PCSIR_LSB_STATE +: 3] & s.state_chg) != 3'h0
      |=> loop_irq_summary)
    else $error("summary missed enabled state flag");

  chk_summary_quiet: assert property (
    s.state_ie == 3'h0 && s.limit_ie == 3'h0 |-> !loop_irq_summary)
    else $error("summary with all enables clear");

  chk_tuning_sum: assert property (
    !reset |=> tuning_word == $past(s.nominal) + $past(ofs_ext))
    else $error("tuning word not nominal plus offset");

  cov_resume_seen: cover property (s.rdy_s2 ##1 resume_set ##1 out_clk_irq);
  cov_state_irq: cover property ($rose(loop_irq_summary));
  cov_bad_addr: cover property (pslverr);
  cov_set_and_clr: cover property ((state_evt & state_clr) != 3'h0);
  cov_limit_race: cover property ((limit_evt & limit_clr) != 3'h0);

endmodule : pcsir_regs
`default_nettype wire

// ### tb/pcsir_tb.sv
// self-checking bench for the loop status and change-flag register bank
// assumes pcsir_regs, its header and package are compiled before this file
`timescale 1ns/100ps
`default_nettype none
`include "pcsir_regs.svh"
module testbench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] ofs = 32'h0;
  logic [31:0] rnd = 32'h63B3ED1B;
  logic stopped = 1'b0;
  logic path_rdy = 1'b0;
  logic fw_in = 1'b0;
  logic [2:0] st = 3'h0;
  logic [2:0] lim = 3'h0;
  logic [2:0] st_c, lim_c, st_ie, lim_ie;
  logic pready, pslverr, out_clk_irq, sum_irq, fw_halt;
  logic [31:0] prdata;
  logic [39:0] nom_w, tune_w, nom_e;
  logic [32:0] expq[$];
  int mismatches = 0;
  int n_tests = 0;
  int i, k;

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  pcsir_regs #(.ADDR_W(12)) i_dut (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .out_clk_stopped(stopped),
    .out_path_ready(path_rdy), .lock_lost_live(st[2]), .tracking_live(st[1]),
    .retained_tuning_offset_word_state(st[0]), .offset_limit_active(lim[2]), .rate_limit_active(lim[1]),
    .phase_slope_limit_active(lim[0]), .firmware_mismatch_in(fw_in),
    .tuning_offset_word(ofs), .out_clk_irq(out_clk_irq), .loop_irq_summary(sum_irq),
    .firmware_mismatch_halt(fw_halt), .nominal_tuning_word(nom_w), .tuning_word(tune_w));

  // ****
  // helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t read got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_sig(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t signal got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_sig

  task automatic tally_and_finish(input logic to);
    if (to)
      mismatches++;
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
  endtask : tick

  // one apb transfer; tog flips tracking and a limit bit in the access cycle to race a clear
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [32:0] ex, input logic tog = 1'b0);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    if (!wr)
      expq.push_back(ex);
    @(posedge core_clk);
    penable <= 1'b1;
    if (tog)
    begin
      st[1] <= ~st[1];
      lim[0] <= ~lim[0];
    end
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      tally_and_finish(1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // read results: each completed read takes the oldest expectation
  always @(posedge core_clk)
    if (psel && penable && pready && !pwrite)
      chk_rd({pslverr, prdata}, expq.pop_front());

  // ****
  // main sequence
  // ****
  initial
  begin
    tick(10);
    reset <= 1'b0;
    tick(1);
    // reset values, output path not yet ready
    apb(1'b0, 8'h53, 8'h00, 33'h0);
    for (k = 0; k < 11; k++)
      apb(1'b0, 8'(k + 'h56), 8'h00, {(k == 2 || k > 6), 32'h0});
    // output clock halt and resume flags
    path_rdy <= 1'b1;
    tick(4);
    stopped <= 1'b1;
    tick(5);
    apb(1'b0, 8'h53, 8'h00, 33'h03);
    chk_sig(out_clk_irq, 40'h0);
    apb(1'b1, 8'h53, 8'h04, '0);
    chk_sig(out_clk_irq, 40'h1);
    apb(1'b1, 8'h53, 8'h06, '0);
    apb(1'b0, 8'h53, 8'h00, 33'h05);
    chk_sig(out_clk_irq, 40'h0);
    stopped <= 1'b0;
    tick(5);
    apb(1'b0, 8'h53, 8'h00, 33'h0C);
    chk_sig(out_clk_irq, 40'h0);
    apb(1'b1, 8'h53, 8'h14, '0);
    chk_sig(out_clk_irq, 40'h1);
    apb(1'b1, 8'h53, 8'h1C, '0);
    apb(1'b0, 8'h53, 8'h00, 33'h14);
    chk_sig(out_clk_irq, 40'h0);
    // random live levels, change flags, enables and clears
    st_c = 3'h0;
    lim_c = 3'h0;
    for (i = 0; i < 12; i++)
    begin
      rnd = lfsr(lfsr(lfsr(rnd)));
      st_c = st_c | (st ^ rnd[2:0]);
      lim_c = lim_c | (lim ^ rnd[5:3]);
      st_ie = rnd[8:6];
      lim_ie = rnd[11:9];
      st <= rnd[2:0];
      lim <= rnd[5:3];
      tick(2);
      apb(1'b0, 8'h56, 8'h00, {27'h0, rnd[2:0], 3'b000});
      apb(1'b0, 8'h57, 8'h00, {30'h0, rnd[5:3]});
      apb(1'b0, 8'h59, 8'h00, {27'h0, st_c, 3'b000});
      apb(1'b0, 8'h5A, 8'h00, {30'h0, lim_c});
      apb(1'b1, 8'h5B, {2'b00, st_ie, 3'b000}, '0);
      apb(1'b1, 8'h5C, {5'h00, lim_ie}, '0);
      chk_sig(sum_irq, {39'h0, |{st_c & st_ie, lim_c & lim_ie}});
      apb(1'b1, 8'h59, {2'b00, rnd[14:12], 3'b000}, '0);
      apb(1'b1, 8'h5A, {5'h00, rnd[17:15]}, '0);
      st_c = st_c & ~rnd[14:12];
      lim_c = lim_c & ~rnd[17:15];
    end
    // masked strobe leaves the enables alone
    pstrb <= 4'h0;
    apb(1'b1, 8'h5B, 8'h00, '0);
    pstrb <= 4'hF;
    apb(1'b0, 8'h5B, 8'h00, {27'h0, st_ie, 3'b000});
    // tracking change in the very cycle of a clear survives it
    apb(1'b1, 8'h59, 8'h38, '0, 1'b1);
    apb(1'b0, 8'h59, 8'h00, 33'h10);
    apb(1'b1, 8'h5A, 8'h07, '0, 1'b1);
    apb(1'b0, 8'h5A, 8'h00, 33'h01);
    // sticky firmware mismatch
    fw_in <= 1'b1;
    tick(1);
    fw_in <= 1'b0;
    tick(3);
    chk_sig(fw_halt, 40'h1);
    apb(1'b0, 8'h57, 8'h00, {28'h0, 2'b10, lim});
    // offset word: low byte read freezes the rest; writes ignored
    rnd = lfsr(rnd);
    ofs <= rnd;
    tick(2);
    apb(1'b1, 8'h65, 8'hFF, '0);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b0, 8'(k + 'h65), 8'h00, {25'h0, rnd[8*k +: 8]});
      ofs <= ~rnd;
    end
    // nominal word and the summed tuning word
    nom_e = {rnd[7:0], lfsr(rnd)};
    for (k = 0; k < 5; k++)
      apb(1'b1, 8'(k + 'h70), nom_e[8*k +: 8], '0);
    for (k = 0; k < 5; k++)
      apb(1'b0, 8'(k + 'h70), 8'h00, {25'h0, nom_e[8*k +: 8]});
    tick(2);
    chk_sig(nom_w, nom_e);
    chk_sig(tune_w, nom_e + {{8{ofs[31]}}, ofs});
    // second reset clears the sticky mismatch
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(1);
    chk_sig(fw_halt, 40'h0);
    tally_and_finish(1'b0);
  end
endmodule : testbench
`default_nettype wire
